// ===== hw/mvs_pkg.sv
// Behaviour
// - multi-byte fields sent most significant first
// - battery answer starts with millivolts, two bytes
// - then capacity byte clamped zero to hundred
// - uptime answer is four-byte millisecond count
// - uptime within fifty ms of last byte
// - settings: link id, zero-padded ascii serial
// - settings confirmation-mode byte, zero or one
// - separate receive and transmit status bytes
// - event-flag byte bits six to zero
// - group count n then n ids
// - channel count m then m channels
// - serial query answers ten ascii bytes
// - parameter write carries sixteen-bit identifier
// - then sixteen-bit content length
// - power save id 7000, length one
// - power save byte ascii zero to three
// - profile id 6600, length one
// - notify interval id 6E00, length two, max 65000
// - vendor control byte and id lead every command
// - battery query is prefix, status, 'v'
`default_nettype none
package mvs_pkg;
  // ------------------------------------------------------------
  // framing characters
  // ------------------------------------------------------------
  localparam logic [7:0] CH_VENDOR = 8'h5A; // vendor control byte
  localparam logic [7:0] CH_VID = 8'h46; // vendor identifier
  localparam logic [7:0] CH_STATUS = 8'h3F; // status selector
  localparam logic [7:0] CH_SERGRP = 8'h74; // serial selector group
  localparam logic [7:0] CH_SETP = 8'h5E; // parameter write selector
  localparam logic [7:0] CH_BATT = 8'h76;
  localparam logic [7:0] CH_TIME = 8'h74;
  localparam logic [7:0] CH_SETTINGS = 8'h75;
  localparam logic [7:0] CH_SERIAL = 8'h73;
  localparam logic [7:0] CH_SUCCESS = 8'h31; // success code
  localparam logic [7:0] CH_ERROR = 8'h33; // syntax error code
  localparam logic [7:0] CH_ASCII0 = 8'h30;
  localparam logic [7:0] CH_ASCII3 = 8'h33;
  // ------------------------------------------------------------
  // parameter identifiers and lengths
  // ------------------------------------------------------------
  localparam logic [15:0] ID_PWRSAVE = 16'h7000;
  localparam logic [15:0] ID_PROFILE = 16'h6600;
  localparam logic [15:0] ID_NOTIFY = 16'h6E00;
  localparam logic [15:0] LEN_ONE = 16'h0001;
  localparam logic [15:0] LEN_TWO = 16'h0002;
  localparam logic [15:0] NOTIFY_MAX = 16'hFDE8; // 65000 ms
  localparam logic [7:0] PCT_MAX = 8'h64; // 100 percent
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_HZ = 50000000;
  localparam int MS_PER_S = 1000;
  localparam int CYC_PER_MS = CLK_HZ / MS_PER_S;
  localparam int UPTIME_TOL_MS = 50;
  // ------------------------------------------------------------
  // response sizes
  // ------------------------------------------------------------
  localparam int SERIAL_Q_LEN = 10;
  localparam int SETTINGS_SER_LEN = 16;
  localparam int SETTINGS_RSV1 = 8; // system and area fields
  localparam int SETTINGS_RSV2 = 17;
  typedef enum logic [2:0] {
    MVS_R_NONE, MVS_R_ERR, MVS_R_BATT, MVS_R_TIME, MVS_R_SET,
    MVS_R_SER, MVS_R_OK
  } mvs_resp_t;
endpackage
`default_nettype wire

// ===== hw/mvs_fifo.sv
`default_nettype none
module mvs_fifo
  import mvs_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
)(
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  // storage array
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_q;
  logic [AW-1:0] rdPtr_q;
  logic [AW:0] count_q;
  wire push = inValid && inReady;
  wire pop = outValid && outReady;
  assign inReady = (count_q != AW'(0) + (AW+1)'(DEPTH));
  assign outValid = (count_q != '0);
  assign outData = mem[rdPtr_q];
  // ------------------------------------------------------------
  // pointers and count
  // ------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end
    else
    begin
      if (push)
        wrPtr_q <= (wrPtr_q == AW'(DEPTH-1)) ? '0 : wrPtr_q + 1'b1;
      if (pop)
        rdPtr_q <= (rdPtr_q == AW'(DEPTH-1)) ? '0 : rdPtr_q + 1'b1;
      count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  // storage write, no reset needed
  always_ff @(posedge clock)
  begin
    if (push)
      mem[wrPtr_q] <= inData;
  end
endmodule
`default_nettype wire

// ===== hw/mvs_cmd.sv
`default_nettype none
module mvs_cmd
  import mvs_pkg::*;
#(
  parameter int GROUPS = 2, // group link ids held
  parameter int CHANS = 2, // static channels held
  parameter int FIFO_DEPTH = 32
)(
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // command bytes from the host terminal
  input wire logic rxValid,
  input wire logic [7:0] rxData,
  // response bytes to the host terminal
  output logic txValid,
  input wire logic txReady,
  output logic [7:0] txData,
  // unit status
  input wire logic [15:0] battMillivolt,
  input wire logic [7:0] battPercent,
  input wire logic [31:0] logicalLinkId,
  input wire logic [79:0] unitSerial,
  input wire logic confirmMode,
  input wire logic rxStatusEn,
  input wire logic txStatusEn,
  input wire logic [6:0] eventFlags,
  input wire logic [GROUPS*32-1:0] groupIds,
  input wire logic [CHANS*16-1:0] staticChans,
  // written settings
  output logic [1:0] powerSaveMode,
  output logic [7:0] activeProfile,
  output logic [15:0] notifyInterval,
  output logic paramWritten
);
  // ------------------------------------------------------------
  // uptime counter
  // ------------------------------------------------------------
  logic [$clog2(CYC_PER_MS)-1:0] msDiv_q;
  logic [31:0] uptime_q;
  wire msTick = (msDiv_q == ($clog2(CYC_PER_MS))'(CYC_PER_MS-1));
  // restarted by reset, counts ms exactly
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      msDiv_q <= '0;
      uptime_q <= '0;
    end
    else
    begin
      msDiv_q <= msTick ? '0 : msDiv_q + 1'b1;
      if (msTick)
        uptime_q <= uptime_q + 32'h0000_0001;
    end
  end
  // ------------------------------------------------------------
  // parser
  // ------------------------------------------------------------
  typedef enum {PS_IDLE, PS_VID, PS_SEL, PS_SUB, PS_SER, PS_HDR,
    PS_VAL, PS_BUSY} mvs_ps_t;
  mvs_ps_t ps_q;
  logic [2:0] hdrCnt_q; // header byte index
  logic [31:0] hdr_q; // id then length, shifted in msb first
  logic [15:0] val_q;
  logic valCnt_q;
  mvs_resp_t resp_q;
  logic [31:0] snap_q; // uptime at last command byte
  logic respDone;
  wire [15:0] pId = hdr_q[31:16];
  wire [15:0] pLen = hdr_q[15:0];
  wire idPs = (pId == ID_PWRSAVE) && (pLen == LEN_ONE);
  wire idPf = (pId == ID_PROFILE) && (pLen == LEN_ONE);
  wire idNt = (pId == ID_NOTIFY) && (pLen == LEN_TWO);
  wire hdrOk = idPs || idPf || idNt;
  wire [15:0] newVal = {val_q[7:0], rxData};
  wire psOk = (rxData >= CH_ASCII0) && (rxData <= CH_ASCII3);
  wire ntOk = newVal <= NOTIFY_MAX;
  wire lastVal = idNt ? valCnt_q : 1'b1;
  // ------------------------------------------------------------
  // command state
  // ------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      ps_q <= PS_IDLE;
      hdrCnt_q <= '0;
      hdr_q <= '0;
      val_q <= '0;
      valCnt_q <= 1'b0;
      resp_q <= MVS_R_NONE;
      snap_q <= '0;
      powerSaveMode <= '0;
      activeProfile <= '0;
      notifyInterval <= '0;
      paramWritten <= 1'b0;
    end
    else
    begin
      paramWritten <= 1'b0;
      // bytes ignored while answering must not move the stamp
      if (rxValid && ps_q != PS_BUSY)
        snap_q <= uptime_q;
      case (ps_q)
        PS_IDLE:
          if (rxValid && rxData == CH_VENDOR)
            ps_q <= PS_VID;
        PS_VID:
          if (rxValid)
            ps_q <= (rxData == CH_VID) ? PS_SEL : PS_IDLE;
        PS_SEL:
          if (rxValid)
          begin
            hdrCnt_q <= '0;
            valCnt_q <= 1'b0;
            if (rxData == CH_STATUS)
              ps_q <= PS_SUB;
            else if (rxData == CH_SERGRP)
              ps_q <= PS_SER;
            else if (rxData == CH_SETP)
              ps_q <= PS_HDR;
            else
            begin
              resp_q <= MVS_R_ERR;
              ps_q <= PS_BUSY;
            end
          end
        PS_SUB:
          if (rxValid)
          begin
            ps_q <= PS_BUSY;
            case (rxData)
              CH_BATT: resp_q <= MVS_R_BATT;
              CH_TIME: resp_q <= MVS_R_TIME;
              CH_SETTINGS: resp_q <= MVS_R_SET;
              default: resp_q <= MVS_R_ERR;
            endcase
          end
        PS_SER:
          if (rxValid)
          begin
            ps_q <= PS_BUSY;
            resp_q <= (rxData == CH_SERIAL) ? MVS_R_SER : MVS_R_ERR;
          end
        PS_HDR:
          if (rxValid)
          begin
            hdr_q <= {hdr_q[23:0], rxData};
            hdrCnt_q <= hdrCnt_q + 3'd1;
            if (hdrCnt_q == 3'd3)
              ps_q <= PS_VAL;
          end
        PS_VAL:
          if (!hdrOk)
          begin
            resp_q <= MVS_R_ERR;
            ps_q <= PS_BUSY;
          end
          else if (rxValid)
          begin
            val_q <= newVal;
            valCnt_q <= 1'b1;
            if (lastVal)
            begin
              ps_q <= PS_BUSY;
              resp_q <= MVS_R_ERR;
              if (idPs && psOk)
              begin
                powerSaveMode <= rxData[1:0];
                resp_q <= MVS_R_OK;
                paramWritten <= 1'b1;
              end
              else if (idPf)
              begin
                activeProfile <= rxData;
                resp_q <= MVS_R_OK;
                paramWritten <= 1'b1;
              end
              else if (idNt && ntOk)
              begin
                notifyInterval <= newVal;
                resp_q <= MVS_R_OK;
                paramWritten <= 1'b1;
              end
            end
          end
        PS_BUSY:
          if (respDone)
          begin
            ps_q <= PS_IDLE;
            resp_q <= MVS_R_NONE;
          end
        default: ps_q <= PS_IDLE;
      endcase
    end
  end
  // ------------------------------------------------------------
  // response byte generator
  // ------------------------------------------------------------
  localparam int SET_LEN = 4 + SETTINGS_SER_LEN + SETTINGS_RSV1 + 5
    + GROUPS * 4 + 1 + CHANS * 2 + SETTINGS_RSV2;
  logic [7:0] idx_q; // byte index within answer
  logic [7:0] gb;
  logic [7:0] respLen;
  logic fifoReady;
  int setOff;
  wire genActive = (ps_q == PS_BUSY);
  wire [7:0] pctClamp = (battPercent > PCT_MAX) ? PCT_MAX : battPercent;
  // selects byte idx of the current answer, msb first
  always_comb
  begin
    setOff = 0;
    gb = 8'h00;
    respLen = 8'd1;
    case (resp_q)
      MVS_R_ERR: gb = CH_ERROR;
      MVS_R_OK: gb = CH_SUCCESS;
      MVS_R_BATT:
      begin
        respLen = 8'd4;
        case (idx_q)
          8'd0: gb = CH_SUCCESS;
          8'd1: gb = battMillivolt[15:8];
          8'd2: gb = battMillivolt[7:0];
          default: gb = pctClamp;
        endcase
      end
      MVS_R_TIME:
      begin
        respLen = 8'd5;
        if (idx_q == 8'd0)
          gb = CH_SUCCESS;
        else
          gb = snap_q[8*(4-int'(idx_q)) +: 8];
      end
      MVS_R_SER:
      begin
        respLen = 8'(SERIAL_Q_LEN + 1);
        if (idx_q == 8'd0)
          gb = CH_SUCCESS;
        else
          gb = unitSerial[8*(SERIAL_Q_LEN-int'(idx_q)) +: 8];
      end
      MVS_R_SET:
      begin
        respLen = 8'(SET_LEN + 1);
        setOff = int'(idx_q) - 1;
        if (idx_q == 8'd0)
          gb = CH_SUCCESS;
        else if (setOff < 4)
          gb = logicalLinkId[8*(3-setOff) +: 8];
        else if (setOff < 4 + SERIAL_Q_LEN)
          gb = unitSerial[8*(SERIAL_Q_LEN-1-(setOff-4)) +: 8];
        else if (setOff < 4 + SETTINGS_SER_LEN + SETTINGS_RSV1)
          gb = 8'h00; // zero pad and reserved
        else
        begin
          setOff = setOff - (4 + SETTINGS_SER_LEN + SETTINGS_RSV1);
          if (setOff == 0)
            gb = {7'h00, confirmMode};
          else if (setOff == 1)
            gb = {7'h00, rxStatusEn};
          else if (setOff == 2)
            gb = {7'h00, txStatusEn};
          else if (setOff == 3)
            gb = {1'b0, eventFlags};
          else if (setOff == 4)
            gb = 8'(GROUPS);
          else if (setOff < 5 + GROUPS * 4)
            gb = groupIds[32*(GROUPS-1-(setOff-5)/4)
              + 8*(3-(setOff-5)%4) +: 8];
          else if (setOff == 5 + GROUPS * 4)
            gb = 8'(CHANS);
          else if (setOff < 6 + GROUPS * 4 + CHANS * 2)
            gb = staticChans[16*(CHANS-1-(setOff-6-GROUPS*4)/2)
              + 8*(1-(setOff-6-GROUPS*4)%2) +: 8];
          else
            gb = 8'h00; // trailing reserved
        end
      end
      default: gb = 8'h00;
    endcase
  end
  wire push = genActive && fifoReady;
  assign respDone = push && (idx_q == respLen - 8'd1);
  // index advances only while the fifo accepts
  always_ff @(posedge clock)
  begin
    if (reset)
      idx_q <= '0;
    else if (respDone)
      idx_q <= '0;
    else if (push)
      idx_q <= idx_q + 8'd1;
  end
  // ------------------------------------------------------------
  // output buffer
  // ------------------------------------------------------------
  mvs_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock(clock),
    .reset(reset),
    .inValid(genActive),
    .inReady(fifoReady),
    .inData(gb),
    .outValid(txValid),
    .outReady(txReady),
    .outData(txData)
  );
  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_pct;
    @(posedge clock) disable iff (reset)
      (push && resp_q == MVS_R_BATT && idx_q == 8'd3)
        |-> (gb <= PCT_MAX)
          && (battPercent > PCT_MAX || gb == battPercent);
  endproperty
  a_pct: assert property (p_pct) else $error("percent over 100");
  property p_notify;
    @(posedge clock) disable iff (reset)
      $changed(notifyInterval) |-> notifyInterval <= NOTIFY_MAX;
  endproperty
  a_notify: assert property (p_notify) else $error("interval high");
  property p_badid;
    @(posedge clock) disable iff (reset)
      (ps_q == PS_VAL && !hdrOk) |=> resp_q == MVS_R_ERR;
  endproperty
  a_badid: assert property (p_badid) else $error("bad id accepted");
  property p_pwr;
    @(posedge clock) disable iff (reset)
      $changed(powerSaveMode) |-> $past(idPs) && $past(ps_q) == PS_VAL;
  endproperty
  a_pwr: assert property (p_pwr) else $error("stray power write");
  property p_batt;
    @(posedge clock) disable iff (reset)
      (ps_q == PS_SUB && rxValid && rxData == CH_BATT)
        |=> resp_q == MVS_R_BATT;
  endproperty
  a_batt: assert property (p_batt) else $error("battery not seen");
  property p_snap;
    @(posedge clock) disable iff (reset)
      (rxValid && ps_q != PS_BUSY) |=> snap_q == $past(uptime_q);
  endproperty
  a_snap: assert property (p_snap) else $error("time snapshot");
  property p_vid;
    @(posedge clock) disable iff (reset)
      (ps_q == PS_VID && rxValid && rxData != CH_VID) |=> ps_q == PS_IDLE;
  endproperty
  a_vid: assert property (p_vid) else $error("bad vendor id");
  property p_uptime;
    @(posedge clock) disable iff (reset)
      msTick |=> uptime_q == $past(uptime_q) + 32'h0000_0001;
  endproperty
  a_uptime: assert property (p_uptime) else $error("uptime step");
endmodule
`default_nettype wire

// ===== testbench/mvs_host_model.sv
`default_nettype none
// ------------------------------------------------------------
// host terminal side: accepts response bytes at a chosen pace
// ------------------------------------------------------------
module mvs_host_model
(
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // response stream from the block
  input wire logic txValid,
  output logic txReady,
  input wire logic [7:0] txData,
  // pace: 0 prompt, 1 every other cycle, 2 halted
  input wire logic [1:0] pace
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] got[$]; // bytes taken, oldest first
  logic phase = 1'b0; // toggles for slow pacing
  initial txReady = 1'b0;
  // a byte counts only at an edge where both sides agree
  always @(posedge clock)
    if (reset === 1'b0 && txValid === 1'b1 && txReady === 1'b1)
      got.push_back(txData);
  // ready moves off the sampling edge, like a real host
  always @(negedge clock)
  begin
    phase <= ~phase;
    txReady <= (pace == 2'd0) || (pace == 2'd1 && phase);
  end
endmodule
`default_nettype wire

// ===== testbench/tb_top.sv
`default_nettype none
module tb_top
  import mvs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ------------------------------------------------------------
  // stimulus and observed signals
  // ------------------------------------------------------------
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic rxValid = 1'b0;
  logic [7:0] rxData = 8'h00;
  logic txValid, txReady, paramWritten;
  logic [7:0] txData, activeProfile;
  logic [1:0] powerSaveMode;
  logic [15:0] notifyInterval;
  logic [1:0] pace = 2'd0;
  logic [15:0] battMillivolt = 16'h0F3C;
  logic [7:0] battPercent = 8'h96; // above 100 on purpose
  logic [31:0] linkId = 32'h1A2B_3C4D;
  logic confMode = 1'b1; // start-up confirmation mode
  logic rxStatEn = 1'b0; // start-up receive status
  logic txStatEn = 1'b1; // start-up transmit status
  logic [6:0] evFlags = 7'h55; // start-up event flags
  logic [79:0] serial = 80'h534E_3132_3334_3536_3700;
  logic [63:0] groups = 64'h1111_2222_3333_4444;
  logic [31:0] chans = 32'h0102_0304;
  int n_mismatch = 0;
  int checks = 0;
  int cycles = 0; // since time zero
  int relCyc = 0; // cycle of the last reset release
  int lastCyc = 0; // cycle the last command byte was taken
  int nWrites = 0; // accepted parameter writes seen
  always #10 clock = ~clock;
  mvs_cmd mvs_cmd_inst (.clock(clock), .reset(reset), .rxValid(rxValid),
    .rxData(rxData), .txValid(txValid), .txReady(txReady),
    .txData(txData), .battMillivolt(battMillivolt),
    .battPercent(battPercent), .logicalLinkId(linkId),
    .unitSerial(serial),
    .confirmMode(confMode), .rxStatusEn(rxStatEn), .txStatusEn(txStatEn),
    .eventFlags(evFlags), .groupIds(groups), .staticChans(chans),
    .powerSaveMode(powerSaveMode), .activeProfile(activeProfile),
    .notifyInterval(notifyInterval), .paramWritten(paramWritten));
  mvs_host_model mvs_host_model_inst (.clock(clock), .reset(reset),
    .txValid(txValid), .txReady(txReady), .txData(txData), .pace(pace));
  // ------------------------------------------------------------
  // cycle count, write pulses and hang guard
  // ------------------------------------------------------------
  always @(posedge clock)
  begin
    cycles++;
    if (paramWritten === 1'b1)
      nWrites++;
    if (cycles == 80000)
    begin
      n_mismatch++;
      $display("BAD timeout expected end seen hang");
      final_report();
    end
  end
  // ------------------------------------------------------------
  // shared helpers
  // ------------------------------------------------------------
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // whole command, one byte per cycle
  task automatic send(logic [7:0] b[$]);
    foreach (b[i])
    begin
      @(negedge clock);
      rxValid = 1'b1;
      rxData = b[i];
    end
    @(negedge clock);
    rxValid = 1'b0;
    lastCyc = cycles;
  endtask
  // bounded wait, then a quiet spell so extra bytes show up
  task automatic wait_bytes(int n);
    int w;
    w = 0;
    while (mvs_host_model_inst.got.size() < n && w < 3000)
    begin
      @(posedge clock);
      w++;
    end
    repeat (20) @(negedge clock);
  endtask
  task automatic expect_resp(string what, logic [7:0] exp[$]);
    wait_bytes(exp.size());
    check({what, " count"}, mvs_host_model_inst.got.size(), exp.size());
    foreach (exp[i])
      if (i < mvs_host_model_inst.got.size())
        check(what, mvs_host_model_inst.got[i], exp[i]);
    mvs_host_model_inst.got.delete();
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic test_battery;
    logic [7:0] pcts[3] = '{8'h96, 8'h64, 8'h2A};
    logic [15:0] volts[3] = '{16'h0F3C, 16'hA5C3, 16'h0001};
    pace = 2'd1; // slow host
    foreach (pcts[i])
    begin
      battPercent = pcts[i];
      battMillivolt = volts[i];
      send('{CH_VENDOR, CH_VID, CH_STATUS, CH_BATT});
      expect_resp("batt", '{CH_SUCCESS, battMillivolt[15:8],
        battMillivolt[7:0], (pcts[i] > PCT_MAX) ? PCT_MAX : pcts[i]});
    end
    $display("test battery done");
  endtask
  task automatic test_uptime;
    logic [31:0] val;
    int ms;
    pace = 2'd0;
    for (int k = 0; k < 2; k++)
    begin
      if (k == 0)
        repeat (60000) @(posedge clock);
      send('{CH_VENDOR, CH_VID, CH_STATUS, CH_TIME});
      ms = (lastCyc - relCyc) / CYC_PER_MS;
      wait_bytes(5);
      check("uptime count", mvs_host_model_inst.got.size(), 5);
      check("uptime lead", mvs_host_model_inst.got[0], CH_SUCCESS);
      val = {mvs_host_model_inst.got[1], mvs_host_model_inst.got[2],
        mvs_host_model_inst.got[3], mvs_host_model_inst.got[4]};
      check("uptime near", 32'(val + UPTIME_TOL_MS >= ms &&
        val <= ms + UPTIME_TOL_MS), 32'h0000_0001);
      mvs_host_model_inst.got.delete();
      // second reset mid-run restarts the count
      @(negedge clock);
      reset = 1'b1;
      repeat (2) @(negedge clock);
      reset = 1'b0;
      relCyc = cycles;
    end
    $display("test uptime done");
  endtask
  task automatic test_serial;
    logic [7:0] e[$];
    e.push_back(CH_SUCCESS);
    for (int i = 0; i < SERIAL_Q_LEN; i++)
      e.push_back(serial[79-8*i -: 8]);
    send('{CH_VENDOR, CH_VID, CH_SERGRP, CH_SERIAL});
    expect_resp("serial", e);
    $display("test serial done");
  endtask
  task automatic test_settings;
    logic [7:0] e[$];
    for (int k = 0; k < 2; k++)
    begin
      if (k == 1)
      begin
        // second pass flips every start-up bit and id
        confMode = 1'b0;
        rxStatEn = 1'b1;
        txStatEn = 1'b0;
        evFlags = 7'h2A;
        linkId = 32'hC0DE_0042;
        groups = 64'h5566_7788_99AA_BBCC;
        chans = 32'hA1B2_C3D4;
      end
      e.delete();
      e.push_back(CH_SUCCESS);
      for (int i = 0; i < 4; i++)
        e.push_back(linkId[31-8*i -: 8]);
      for (int i = 0; i < SETTINGS_SER_LEN; i++)
        e.push_back(i < 10 ? serial[79-8*i -: 8] : 8'h00);
      for (int i = 0; i < SETTINGS_RSV1; i++)
        e.push_back(8'h00);
      e.push_back({7'h00, confMode});
      e.push_back({7'h00, rxStatEn});
      e.push_back({7'h00, txStatEn});
      e.push_back({1'b0, evFlags});
      e.push_back(8'h02);
      for (int i = 0; i < 8; i++)
        e.push_back(groups[63-8*i -: 8]);
      e.push_back(8'h02);
      for (int i = 0; i < 4; i++)
        e.push_back(chans[31-8*i -: 8]);
      for (int i = 0; i < SETTINGS_RSV2; i++)
        e.push_back(8'h00);
      // first pass: host halted, the fifo fills and holds
      pace = (k == 0) ? 2'd2 : 2'd0;
      send('{CH_VENDOR, CH_VID, CH_STATUS, CH_SETTINGS});
      if (k == 0)
      begin
        repeat (200) @(negedge clock);
        check("held valid", txValid, 32'h0000_0001);
        pace = 2'd1;
      end
      expect_resp("settings", e);
    end
    $display("test settings done");
  endtask
  task automatic test_params;
    int w0;
    pace = 2'd0;
    for (logic [7:0] d = CH_ASCII0; d <= CH_ASCII3; d++)
    begin
      w0 = nWrites;
      send('{CH_VENDOR, CH_VID, CH_SETP, 8'h70, 8'h00, 8'h00, 8'h01, d});
      expect_resp("power ok", '{CH_SUCCESS});
      check("power mode", powerSaveMode, 2'(d - CH_ASCII0));
      check("power pulse", nWrites - w0, 1);
    end
    send('{CH_VENDOR, CH_VID, CH_SETP, 8'h66, 8'h00, 8'h00, 8'h01, 8'h07});
    expect_resp("profile ok", '{CH_SUCCESS});
    check("profile", activeProfile, 8'h07);
    send('{CH_VENDOR, CH_VID, CH_SETP, 8'h6E, 8'h00, 8'h00, 8'h02,
      8'hFD, 8'hE8});
    expect_resp("notify ok", '{CH_SUCCESS});
    check("notify", notifyInterval, NOTIFY_MAX);
    w0 = nWrites;
    send('{CH_VENDOR, CH_VID, CH_SETP, 8'h6E, 8'h00, 8'h00, 8'h02,
      8'hFD, 8'hE9});
    expect_resp("notify big", '{CH_ERROR});
    send('{CH_VENDOR, CH_VID, CH_SETP, 8'h70, 8'h00, 8'h00, 8'h01, 8'h34});
    expect_resp("power bad", '{CH_ERROR});
    send('{CH_VENDOR, CH_VID, CH_SETP, 8'h12, 8'h34, 8'h00, 8'h01});
    expect_resp("id unknown", '{CH_ERROR});
    send('{CH_VENDOR, CH_VID, CH_SETP, 8'h66, 8'h00, 8'h00, 8'h02});
    expect_resp("len bad", '{CH_ERROR});
    check("no pulse", nWrites - w0, 0);
    check("notify kept", notifyInterval, NOTIFY_MAX);
    $display("test params done");
  endtask
  task automatic test_refuse;
    logic [7:0] noBytes[$]; // no answer at all
    send('{CH_VENDOR, 8'h58, CH_STATUS, CH_BATT});
    expect_resp("bad prefix", noBytes);
    send('{CH_VENDOR, CH_VID, CH_STATUS, 8'h71});
    expect_resp("bad selector", '{CH_ERROR});
    $display("test refuse done");
  endtask
  // ------------------------------------------------------------
  // verdict and main sequence
  // ------------------------------------------------------------
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(negedge clock);
    reset = 1'b0;
    relCyc = cycles;
    test_battery();
    test_uptime();
    test_serial();
    test_settings();
    test_params();
    test_refuse();
    final_report();
  end
endmodule
`default_nettype wire
